// *** hw/prox_sensor_i2c_cmd_regs.sv ***
// i2c target, command pointer and register map of the proximity sensor
//
// Functional notes
// - 7-bit addressed i2c target, standard/fast
// - combined: command, repeated start, reads
// - plain read uses latched pointer address
// - msb-clear first byte is data
// - bits 6:5 select transfer type
// - repeat type keeps address fixed
// - auto-increment advances after each byte
// - bits 4:0 address or function code
// - function 00101 clears proximity interrupt
// - write-only command pointer resets zero
// - enable register resets zero, read/write
// - two 16-bit thresholds, read/write, zero
// - result bytes read-only, reset zero
// - enable bit 5 masks interrupt
// - interrupt set by the core's proximity event; thresholds are only stored, never compared here
`include "prox_i2c_params.svh"
`timescale 1ns/10ps
`default_nettype none
module prox_sensor_i2c_cmd_regs
  import prox_i2c_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = `I2C_ADDR_RESET,
  parameter logic [7:0] PART_ID     = `PART_ID_VALUE   // arbitrary value
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // i2c pins, sampled synchronously
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // measurement core side
  input  wire logic [15:0] prox_result_i,
  input  wire logic        prox_result_vld_i,
  input  wire logic        prox_event_i,
  output logic             prox_int_o,
  output logic             prox_int_clr_o,
  output logic [7:0]       function_enable_o
);
  initial begin
    if (TARGET_ADDR == 7'h00) $error("general call address not allowed");
  end

  ////////////////////////////////////////////////////////////////////////
  // bus edge detection
  logic scl_q_reg;
  logic sda_q_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  // start and stop need scl high on two samples, so a slow edge is not taken
  always_comb begin
    scl_rise   = scl_i & ~scl_q_reg;
    scl_fall   = ~scl_i & scl_q_reg;
    start_seen = scl_i & scl_q_reg & sda_q_reg & ~sda_i;
    stop_seen  = scl_i & scl_q_reg & ~sda_q_reg & sda_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // protocol state
  bus_state_t state_reg, state_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic       is_read_reg, is_read_next;
  // only the first byte after a write address may load the pointer
  logic       first_reg, first_next;
  logic [7:0] cmd_reg, cmd_next;
  logic       drive_reg, drive_next;
  logic       int_reg, int_next;
  logic [7:0] result_lsb_reg, result_lsb_next;
  logic [7:0] result_msb_reg, result_msb_next;
  logic       clr_reg, clr_next;
  logic       mem_we;
  logic [7:0] mem_rdata;
  logic [4:0] ptr;
  logic [7:0] rd_byte;
  xfer_type_t xtype;

  function automatic logic is_store_reg(input logic [4:0] a);
    // registers that live in the byte store and are writable
    return (a <= `OFF_WAIT) || ((a >= `OFF_LO_THR_LSB) && (a <= `OFF_CONTROL));
  endfunction

  // only auto-increment moves the pointer; the 5-bit address wraps 31 to 0
  function automatic logic [4:0] advance(input logic [7:0] c);
    return (xfer_type_t'(c[`CMD_TYPE_HI:`CMD_TYPE_LO]) == XFER_AUTO_INC) ?
           c[`CMD_ADDR_HI:0] + 5'd1 : c[`CMD_ADDR_HI:0];
  endfunction

  assign ptr   = cmd_reg[`CMD_ADDR_HI:0];
  assign xtype = xfer_type_t'(cmd_reg[`CMD_TYPE_HI:`CMD_TYPE_LO]);

  // byte store; reads and writes share the held pointer
  prox_reg_mem #(
    .AW (5)
  ) u_mem (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .we_i    (mem_we),
    .waddr_i (ptr),
    .wdata_i (shift_reg),
    .raddr_i (ptr),
    .rdata_o (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // read mux; registered store data has one cycle of latency, ample at scl rate
  always_comb begin
    unique case (ptr)
      `OFF_PART_ID:    rd_byte = PART_ID;
      `OFF_STATUS:     rd_byte = {2'b00, int_reg, 5'b00000};
      `OFF_RESULT_LSB: rd_byte = result_lsb_reg;
      `OFF_RESULT_MSB: rd_byte = result_msb_reg;
      default:         rd_byte = is_store_reg(ptr) ? mem_rdata : 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // byte engine: address match, command decode, data shift
  always_comb begin
    state_next      = state_reg;
    shift_next      = shift_reg;
    bit_cnt_next    = bit_cnt_reg;
    is_read_next    = is_read_reg;
    first_next      = first_reg;
    cmd_next        = cmd_reg;
    drive_next      = drive_reg;
    clr_next        = 1'b0;
    mem_we          = 1'b0;
    result_lsb_next = result_lsb_reg;
    result_msb_next = result_msb_reg;
    if (prox_result_vld_i) begin
      result_lsb_next = prox_result_i[7:0];
      result_msb_next = prox_result_i[15:8];
    end
    if (stop_seen) begin
      state_next = ST_IDLE;
      drive_next = 1'b0;
    end else if (start_seen) begin
      state_next   = ST_ADDR;
      bit_cnt_next = 4'd0;
      drive_next   = 1'b0;
    end else begin
      unique case (state_reg)
        // no frame, foreign address or read ended by nack: keep off the bus until start or stop
        ST_IDLE, ST_SKIP: ;
        ST_ADDR: begin
          if (scl_rise) begin
            shift_next   = {shift_reg[6:0], sda_i};
            bit_cnt_next = bit_cnt_reg + 4'd1;
          end else if (scl_fall && bit_cnt_reg == 4'd8) begin
            if (shift_reg[7:1] == TARGET_ADDR) begin
              is_read_next = shift_reg[0];
              first_next   = 1'b1;
              drive_next   = 1'b1;
              state_next   = ST_ADDR_ACK;
            end else begin
              state_next = ST_SKIP;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_next = 4'd0;
            if (is_read_reg) begin
              // pointer settled long ago, so the store data is valid here
              shift_next = rd_byte;
              drive_next = ~rd_byte[7];
              state_next = ST_RD_BYTE;
            end else begin
              drive_next = 1'b0;
              state_next = ST_WR_BYTE;
            end
          end
        end
        ST_WR_BYTE: begin
          if (scl_rise) begin
            shift_next   = {shift_reg[6:0], sda_i};
            bit_cnt_next = bit_cnt_reg + 4'd1;
          end else if (scl_fall && bit_cnt_reg == 4'd8) begin
            drive_next = 1'b1;
            state_next = ST_WR_ACK;
            if (first_reg && shift_reg[`CMD_SEL_BIT]) begin
              first_next = 1'b0;
              if (shift_reg[`CMD_TYPE_HI:`CMD_TYPE_LO] == XFER_SPECIAL) begin
                // special functions leave the held pointer alone
                if (shift_reg[`CMD_ADDR_HI:0] == `CMD_FUNC_INT_CLR) begin
                  clr_next = 1'b1;
                end
              end else begin
                cmd_next = shift_reg;
              end
            end else begin
              first_next = 1'b0;
              if (xtype != XFER_SPECIAL && is_store_reg(ptr)) begin
                mem_we = 1'b1;
              end
              cmd_next[`CMD_ADDR_HI:0] = advance(cmd_reg);
            end
          end
        end
        ST_WR_ACK: begin
          if (scl_fall) begin
            drive_next   = 1'b0;
            bit_cnt_next = 4'd0;
            state_next   = ST_WR_BYTE;
          end
        end
        ST_RD_BYTE: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'd7) begin
              drive_next = 1'b0;
              state_next = ST_RD_ACK;
              cmd_next[`CMD_ADDR_HI:0] = advance(cmd_reg);
            end else begin
              shift_next   = {shift_reg[6:0], 1'b0};
              drive_next   = ~shift_reg[6];
              bit_cnt_next = bit_cnt_reg + 4'd1;
            end
          end
        end
        ST_RD_ACK: begin
          // a released sda is the controller's nack, which ends the read
          if (scl_rise) begin
            state_next = sda_i ? ST_SKIP : ST_ADDR_ACK;
            is_read_next = 1'b1;
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt: the event from the comparator wins over a clear
  always_comb begin
    int_next = int_reg;
    if (clr_reg) int_next = 1'b0;
    if (prox_event_i) int_next = 1'b1;
  end

  // reset levels of the pin copies match the idle bus, so no false edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_q_reg      <= 1'b1;
      sda_q_reg      <= 1'b1;
      state_reg      <= ST_IDLE;
      shift_reg      <= 8'h00;
      bit_cnt_reg    <= 4'h0;
      is_read_reg    <= 1'b0;
      first_reg      <= 1'b0;
      cmd_reg        <= `CMD_RESET;
      drive_reg      <= 1'b0;
      clr_reg        <= 1'b0;
      int_reg        <= 1'b0;
      result_lsb_reg <= `RST_ZERO;
      result_msb_reg <= `RST_ZERO;
    end else begin
      scl_q_reg      <= scl_i;
      sda_q_reg      <= sda_i;
      state_reg      <= state_next;
      shift_reg      <= shift_next;
      bit_cnt_reg    <= bit_cnt_next;
      is_read_reg    <= is_read_next;
      first_reg      <= first_next;
      cmd_reg        <= cmd_next;
      drive_reg      <= drive_next;
      clr_reg        <= clr_next;
      int_reg        <= int_next;
      result_lsb_reg <= result_lsb_next;
      result_msb_reg <= result_msb_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // enable register is kept in the store, a shadow copy drives the mask
  logic [7:0] enable_reg, enable_next;
  always_comb begin
    enable_next = enable_reg;
    if (mem_we && ptr == `OFF_ENABLE) enable_next = shift_reg;
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) enable_reg <= `RST_ZERO;
    else enable_reg <= enable_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign sda_o             = 1'b0;  // open drain: only ever pulls low
  assign sda_oe_o          = drive_reg;
  assign prox_int_o        = int_reg & enable_reg[`EN_INT_MASK_BIT];
  assign prox_int_clr_o    = clr_reg;
  assign function_enable_o = enable_reg;
endmodule
`default_nettype wire

// *** hw/prox_i2c_params.svh ***
// register offsets, field positions, reset values and bus constants
`ifndef PROX_I2C_PARAMS_SVH
`define PROX_I2C_PARAMS_SVH
`define CMD_SEL_BIT        7
`define CMD_TYPE_HI        6
`define CMD_TYPE_LO        5
`define CMD_ADDR_HI        4
`define CMD_FUNC_NOP       5'h00
`define CMD_FUNC_INT_CLR   5'h05
`define CMD_RESET          8'h00
`define OFF_ENABLE         5'h00
`define OFF_LEGACY_TIME    5'h01
`define OFF_CONV_TIME      5'h02
`define OFF_WAIT           5'h03
`define OFF_LO_THR_LSB     5'h08
`define OFF_LO_THR_MSB     5'h09
`define OFF_HI_THR_LSB     5'h0a
`define OFF_HI_THR_MSB     5'h0b
`define OFF_FILTER         5'h0c
`define OFF_CONFIG         5'h0d
`define OFF_PULSE          5'h0e
`define OFF_CONTROL        5'h0f
`define OFF_PART_ID        5'h12
`define OFF_STATUS         5'h13
`define OFF_RESULT_LSB     5'h18
`define OFF_RESULT_MSB     5'h19
`define RST_ZERO           8'h00
`define RST_CONV_TIME      8'hff
`define RST_WAIT           8'hff
`define EN_INT_MASK_BIT    5
`define I2C_ADDR_RESET     7'h39
`define PART_ID_VALUE      8'h5a
`endif

// *** hw/prox_i2c_pkg.sv ***
// types shared by the proximity sensor target interface
package prox_i2c_pkg;
  typedef enum logic [1:0] {
    XFER_REPEAT,
    XFER_AUTO_INC,
    XFER_RESERVED,
    XFER_SPECIAL
  } xfer_type_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR_BYTE,
    ST_WR_ACK,
    ST_RD_BYTE,
    ST_RD_ACK,
    ST_SKIP
  } bus_state_t;
endpackage

// *** hw/prox_reg_mem.sv ***
// 32-entry byte register store with registered read data
`include "prox_i2c_params.svh"
`timescale 1ns/10ps
`default_nettype none
module prox_reg_mem #(
  parameter int AW = 5
) (
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          srst_i,
  // write port
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  // read port
  input  wire logic [AW-1:0] raddr_i,
  output logic      [7:0]    rdata_o
);
  initial begin
    if (AW < 5) $error("address width too small");
  end
  logic [7:0] mem_reg [2**AW];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = mem_reg[raddr_i];
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_reg <= 8'h00;
      for (int i = 0; i < 2**AW; i++) begin
        mem_reg[i] <= 8'h00;
      end
      mem_reg[`OFF_CONV_TIME] <= `RST_CONV_TIME;
      mem_reg[`OFF_WAIT]      <= `RST_WAIT;
    end else begin
      rdata_reg <= rdata_next;
      if (we_i) begin
        mem_reg[waddr_i] <= wdata_i;
      end
    end
  end
  assign rdata_o = rdata_reg;
endmodule
`default_nettype wire

// *** sim/prox_i2c_chk.sv ***
// assertion checker for the proximity sensor target interface
`timescale 1ns/10ps
`default_nettype none
module prox_i2c_chk (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       srst_i,
  // bus pins
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  // core side
  input wire logic       prox_event_i,
  input wire logic       prox_int_o,
  input wire logic       prox_int_clr_o,
  input wire logic [7:0] function_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////
  a_sda_low_only: assert property (sda_o == 1'b0)
    else $error("sda data output not low");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("sda enable moved while scl high");
  a_reset_all_zero: assert property ($fell(srst_i) |->
    function_enable_o == 8'h00 && !prox_int_o && !sda_oe_o)
    else $error("outputs not cleared by reset");
  a_enable_scl_low: assert property ($changed(function_enable_o) |-> !scl_i)
    else $error("enable changed outside a byte boundary");
  // enable output is the mask register itself, so it never leads or trails the internal term; the window still allows one cycle
  a_int_needs_mask: assert property ($rose(prox_int_o) |-> ##[0:1] function_enable_o[5])
    else $error("interrupt raised while masked");
  a_event_sets_int: assert property (prox_event_i && function_enable_o[5] |-> ##[1:2] prox_int_o)
    else $error("event did not raise interrupt");
  a_clr_one_cycle: assert property (prox_int_clr_o |=> !prox_int_clr_o)
    else $error("clear pulse longer than one cycle");
  a_clr_drops_int: assert property (prox_int_clr_o && !prox_event_i |-> ##[1:2] !prox_int_o)
    else $error("clear did not drop interrupt");
  a_int_holds_level: assert property (
    prox_int_o && !prox_int_clr_o && !$past(prox_int_clr_o)
    |=> prox_int_o || !function_enable_o[5] || prox_int_clr_o)
    else $error("interrupt dropped without clear");
  c_clear_seen: cover property (prox_int_clr_o);
  c_int_seen: cover property ($rose(prox_int_o));
  c_ack_seen: cover property ($rose(sda_oe_o));
endmodule
bind prox_sensor_i2c_cmd_regs prox_i2c_chk prox_i2c_chk_i (
  .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .prox_event_i(prox_event_i), .prox_int_o(prox_int_o), .prox_int_clr_o(prox_int_clr_o),
  .function_enable_o(function_enable_o));
`default_nettype wire

// *** sim/i2c_host_model.sv ***
// bus controller model driving scl and the sda pull-down
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model (
  // clock
  input wire logic clk_i,
  // bus
  input wire logic sda_line_i,
  output var logic scl_o,
  output var logic sda_o
);
  // released sda reads as the pull-up level
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  ////////////////////////////////////////
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic bit_x(input logic b, output logic seen);
    sda_o <= b;
    tk(2);
    scl_o <= 1'b1;
    tk(3);
    seen = sda_line_i;
    tk(1);
    scl_o <= 1'b0;
    tk(2);
  endtask
  // also serves as repeated start
  task automatic start();
    sda_o <= 1'b1;
    tk(2);
    scl_o <= 1'b1;
    tk(4);
    sda_o <= 1'b0;
    tk(4);
    scl_o <= 1'b0;
    tk(2);
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    tk(2);
    scl_o <= 1'b1;
    tk(4);
    sda_o <= 1'b1;
    tk(4);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = ~s;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      b[i] = s;
    end
    bit_x(last, s);
  endtask
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench for the proximity sensor target interface
`include "prox_i2c_params.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk_i, srst_i, scl, sda_hst, sda_o, sda_oe, int_o, clr_o, evt, res_vld, ack;
  logic [15:0] res;
  logic [7:0]  fen;
  int          num_errors = 0;
  int          n_compared = 0;
  int          n_clr = 0;
  wire logic   sda_line = sda_hst & (~sda_oe | sda_o);
  prox_sensor_i2c_cmd_regs prox_sensor_i2c_cmd_regs_i (
    .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .prox_result_i(res), .prox_result_vld_i(res_vld),
    .prox_event_i(evt), .prox_int_o(int_o), .prox_int_clr_o(clr_o),
    .function_enable_o(fen));
  i2c_host_model i2c_host_model_i (
    .clk_i(clk_i), .sda_line_i(sda_line), .scl_o(scl), .sda_o(sda_hst));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic put(input logic [7:0] b);
    logic a;
    i2c_host_model_i.put_byte(b, a);
    check("ack", {7'h00, a}, 8'h01);
  endtask
  task automatic wr(input logic [7:0] q[$]);
    i2c_host_model_i.start();
    put({`I2C_ADDR_RESET, 1'b0});
    foreach (q[i]) put(q[i]);
    i2c_host_model_i.stop();
  endtask
  task automatic rd_chk(input int c, input logic [7:0] cmd, input string what,
                        input logic [7:0] exp[$]);
    logic [7:0] b;
    i2c_host_model_i.start();
    if (c != 0) begin
      put({`I2C_ADDR_RESET, 1'b0});
      put(cmd);
      i2c_host_model_i.start();
    end
    put({`I2C_ADDR_RESET, 1'b1});
    foreach (exp[i]) begin
      i2c_host_model_i.get_byte(i == exp.size() - 1, b);
      check(what, b, exp[i]);
    end
    i2c_host_model_i.stop();
  endtask
  task automatic fire();
    evt <= 1'b1;
    @(posedge clk_i);
    evt <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  ////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // one-cycle clear pulses, counted as they pass
  always @(posedge clk_i) begin
    if (clr_o === 1'b1) n_clr <= n_clr + 1;
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    end_of_test();
  end
  initial begin
    srst_i = 1'b1;
    evt = 1'b0;
    res_vld = 1'b0;
    res = 16'h0000;
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd_chk(0, 8'h00, "reset pointer", {8'h00, 8'h00});
    rd_chk(1, 8'ha0, "reset map", {8'h00, 8'h00, 8'hff, 8'hff});
    rd_chk(1, 8'ha8, "thresholds", {8'h00, 8'h00, 8'h00, 8'h00});
    rd_chk(1, 8'hb2, "id status", {`PART_ID_VALUE, 8'h00});
    $display("test reset values done");
    wr({8'ha1, 8'hff, 8'h11, 8'h22});
    rd_chk(1, 8'ha1, "auto inc", {8'hff, 8'h11, 8'h22});
    wr({8'h88, 8'h12, 8'h34});
    rd_chk(1, 8'h88, "repeat", {8'h34, 8'h34, 8'h34});
    rd_chk(0, 8'h00, "no command", {8'h34});
    wr({8'h89});
    wr({8'h55});
    rd_chk(0, 8'h00, "data only", {8'h55});
    $display("test pointer modes done");
    res <= 16'hbeef;
    res_vld <= 1'b1;
    @(posedge clk_i);
    res_vld <= 1'b0;
    rd_chk(1, 8'hb8, "result", {8'hef, 8'hbe});
    wr({8'hb8, 8'h77, 8'h66});
    rd_chk(1, 8'hb8, "read only", {8'hef, 8'hbe});
    rd_chk(1, 8'ha5, "unmapped", {8'h00});
    i2c_host_model_i.start();
    i2c_host_model_i.put_byte(8'ha0, ack);
    check("foreign ack", {7'h00, ack}, 8'h00);
    i2c_host_model_i.stop();
    $display("test access rights done");
    wr({8'h80, 8'h20});
    check("enable out", fen, 8'h20);
    fire();
    check("int raised", {7'h00, int_o}, 8'h01);
    rd_chk(1, 8'h93, "status", {8'h20});
    wr({8'he0});
    check("int after nop", {7'h00, int_o}, 8'h01);
    check("clear pulses", n_clr[7:0], 8'h00);
    wr({8'he5});
    check("int after clear", {7'h00, int_o}, 8'h00);
    check("clear pulses", n_clr[7:0], 8'h01);
    rd_chk(0, 8'h00, "status kept", {8'h00});
    wr({8'h80, 8'h00});
    fire();
    check("masked int", {7'h00, int_o}, 8'h00);
    wr({8'he5});
    check("clear pulses", n_clr[7:0], 8'h02);
    $display("test interrupt done");
    end_of_test();
  end
endmodule
`default_nettype wire
